/* src/flash_ctl_defines.vh */
// constants for the parallel flash host controller
// assumes a 10 MHz controller clock and a 16-bit flash data bus
`ifndef FLASH_CTL_DEFINES_VH
`define FLASH_CTL_DEFINES_VH

`define CLOCK_MHZ            32'd10

// user operation codes
`define OP_READ              3'h0
`define OP_PROGRAM           3'h1
`define OP_SECTOR_ERASE      3'h2
`define OP_CHIP_ERASE        3'h3
`define OP_SET_CONFIG        3'h4
`define OP_IDENT_LEAVE       3'h5
`define OP_DEVICE_RESET      3'h6

// command sequence addresses and codes
`define UNLOCK1_ADDR         20'h0_0555
`define UNLOCK1_DATA         16'h00AA
`define UNLOCK2_ADDR         20'h0_02AA
`define UNLOCK2_DATA         16'h0055
`define PROGRAM_CODE         16'h00A0
`define ERASE_SETUP_CODE     16'h0080
`define SECTOR_CONFIRM_CODE  16'h0030
`define CHIP_CONFIRM_CODE    16'h0010
`define CONFIG_SET_CODE      16'h00D0
`define IDENT_LEAVE_CODE     16'h00F0

// sequence lengths in bus writes
`define PROGRAM_STEPS        3'h4
`define ERASE_STEPS          3'h6
`define CONFIG_STEPS         3'h4
`define LEAVE_STEPS          3'h1

// status bit positions on the data lines
`define POLL_STATUS_BIT      7
`define TOGGLE_STATUS_BIT    6
`define FAIL_STATUS_BIT      5
`define SUPPLY_STATUS_BIT    3

// status configuration values
`define CFG_AUTO_READ        2'h0
`define CFG_STATUS_HOLD      2'h1

// device reset pulse and recovery, in cycles
`define RESET_PULSE_CYCLES   8'h08
`define RESET_RECOVER_CYCLES 8'h02

`endif

/* src/flash_bus_cycle.v */
// one asynchronous flash bus cycle: a single read or a single write
// assumes dq_in is synchronous to clock and the device answers within two cycles
`timescale 1ns/1ps
`include "flash_ctl_defines.vh"

module flash_bus_cycle (
  // clock and reset
  input  wire        clock,
  input  wire        rst_b,
  // request side
  input  wire        start,
  input  wire        write,
  input  wire [19:0] addr,
  input  wire [15:0] wdata,
  output reg         done,
  output reg  [15:0] rdata,
  // flash pins
  output reg         ce_b,
  output reg         oe_b,
  output reg         we_b,
  output reg  [19:0] flash_addr,
  output reg  [15:0] dq_out,
  output reg         dq_oe,
  input  wire [15:0] dq_in
);

  reg       active_q;
  reg       wr_q;
  reg [1:0] ph_q;

  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      active_q   <= 1'b0;
      wr_q       <= 1'b0;
      ph_q       <= 2'h0;
      done       <= 1'b0;
      rdata      <= 16'h0000;
      ce_b       <= 1'b1;
      oe_b       <= 1'b1;
      we_b       <= 1'b1;
      flash_addr <= 20'h0_0000;
      dq_out     <= 16'h0000;
      dq_oe      <= 1'b0;
    end else begin
      done <= 1'b0;
      if (!active_q) begin
        if (start) begin
          // address and chip enable settle before the write strobe moves; a read drops output enable with them
          active_q   <= 1'b1;
          wr_q       <= write;
          ph_q       <= 2'h0;
          flash_addr <= addr;
          dq_out     <= wdata;
          dq_oe      <= write;
          ce_b       <= 1'b0;
          oe_b       <= write; // R1
        end
      end else begin
        ph_q <= ph_q + 2'h1;
        if (wr_q) begin
          case (ph_q)
            2'h0: we_b <= 1'b0; // R23
            2'h1: we_b <= 1'b1; // R23
            default: begin
              // data held one cycle past the rising strobe
              ce_b     <= 1'b1;
              dq_oe    <= 1'b0;
              done     <= 1'b1;
              active_q <= 1'b0;
            end
          endcase
        end else if (ph_q == 2'h1) begin
          rdata    <= dq_in;
          ce_b     <= 1'b1;
          oe_b     <= 1'b1;
          done     <= 1'b1;
          active_q <= 1'b0;
        end
      end
    end
  end

endmodule

/* src/flash_host_ctl.v */
// host controller for a 1M x 16 parallel flash: read, program, erase, status polling
// assumes the device answers its pins as documented and dq_in is synchronous to clock
//
// Summary of operation
// (R1) read with chip and output enable low
// (R2) device reset aborts operation, floats outputs
// (R3) after reset device returns to read
// (R4) erased bits read as one
// (R5) chip erase is six writes, internally timed
// (R6) chip erase skips locked sectors
// (R7) thirty-nine individually erasable sectors
// (R8) sector erase uses six bus writes
// (R9) sector address then confirm on sixth write
// (R10) protected sector erase ends at once
// (R11) word program is four writes
// (R12) commands ignored while program runs
// (R13) reset during program corrupts the word
// (R14) program only clears bits
// (R15) unverified operation sets fail bit
// (R16) low protect supply refuses program/erase
// (R17) configuration selects auto read or exit
// (R18) failure needs identification leave command
// (R19) configuration defaults zero, set by command
// (R20) config zero: polled bit complement or zero
// (R21) config one: polled bit low while busy
// (R22) toggle bit flips on each read
// (R23) address on last fall, data first rise
// (R24) fail status bit set for protected target
// (R25) supply status bit reports low supply
// (R26) mismatched sequence step returns to read
`timescale 1ns/1ps
`include "flash_ctl_defines.vh"

module flash_host_ctl #(
  parameter [31:0] word_program_time_us     = 32'd1000,
  parameter [31:0] sector_erase_max_time_us = 32'd1000000,
  parameter [31:0] chip_erase_max_time_us   = 32'd10000000
) (
  // clock and reset
  input  wire        clock,
  input  wire        rst_b,
  // user command port
  input  wire        cmd_valid,
  output wire        cmd_ready,
  input  wire [2:0]  cmd_op,
  input  wire [19:0] cmd_addr,
  input  wire [15:0] cmd_data,
  // user response port
  output reg         rsp_valid,
  output reg  [15:0] rsp_data,
  output reg         rsp_fail,
  output reg         rsp_supply_low,
  output reg         rsp_timeout,
  output wire [1:0]  status_config,
  // flash pins
  output wire        ce_b,
  output wire        oe_b,
  output wire        we_b,
  output reg         flash_reset_b,
  output wire [19:0] flash_addr,
  output wire [15:0] dq_out,
  output wire        dq_oe,
  input  wire [15:0] dq_in
);

  localparam [31:0] program_limit = word_program_time_us * `CLOCK_MHZ;
  localparam [31:0] sector_limit  = sector_erase_max_time_us * `CLOCK_MHZ;
  localparam [31:0] chip_limit    = chip_erase_max_time_us * `CLOCK_MHZ;

  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_SEQ  = 3'h1;
  localparam [2:0] S_READ = 3'h2;
  localparam [2:0] S_POLL = 3'h3;
  localparam [2:0] S_EXIT = 3'h4;
  localparam [2:0] S_RST  = 3'h5;
  localparam [2:0] S_RESP = 3'h6;

  reg [2:0]  state_q;
  reg [2:0]  op_q;
  reg [19:0] addr_q;
  reg [15:0] data_q;
  reg [2:0]  step_q;
  reg [1:0]  cfg_q;
  reg [15:0] first_q;
  reg [1:0]  pk_q;
  reg [31:0] timer_q;
  reg [31:0] limit_q;
  reg [7:0]  rcnt_q;
  reg        rrec_q;
  reg        pend_q;

  wire        bus_done;
  wire [15:0] bus_rdata;
  reg         bus_write;
  reg  [19:0] bus_addr;
  reg  [15:0] bus_wdata;
  reg  [2:0]  last_step;
  wire        need_bus = (state_q == S_SEQ) | (state_q == S_READ) | (state_q == S_POLL) | (state_q == S_EXIT);
  wire        bus_start = need_bus & ~pend_q & ~((state_q == S_POLL) & (timer_q >= limit_q));
  wire        hold_cfg = (cfg_q == `CFG_STATUS_HOLD);
  wire        stopped = (first_q[`TOGGLE_STATUS_BIT] == bus_rdata[`TOGGLE_STATUS_BIT]);
  wire        status_flag = bus_rdata[`FAIL_STATUS_BIT] | bus_rdata[`SUPPLY_STATUS_BIT];

  assign cmd_ready     = (state_q == S_IDLE);
  assign status_config = cfg_q;

  // address and data of the current sequence step
  always @* begin
    bus_write = 1'b1;
    bus_addr  = `UNLOCK1_ADDR;
    bus_wdata = `UNLOCK1_DATA;
    last_step = `PROGRAM_STEPS - 3'h1;
    case (op_q)
      `OP_PROGRAM:      last_step = `PROGRAM_STEPS - 3'h1;
      `OP_SECTOR_ERASE: last_step = `ERASE_STEPS - 3'h1;
      `OP_CHIP_ERASE:   last_step = `ERASE_STEPS - 3'h1;
      `OP_SET_CONFIG:   last_step = `CONFIG_STEPS - 3'h1;
      default:          last_step = `LEAVE_STEPS - 3'h1;
    endcase
    if (state_q == S_EXIT) begin
      bus_wdata = `IDENT_LEAVE_CODE; // R18
    end else if (state_q == S_READ || state_q == S_POLL) begin
      bus_write = 1'b0;
      bus_addr  = (op_q == `OP_CHIP_ERASE) ? 20'h0_0000 : addr_q;
    end else if (op_q == `OP_IDENT_LEAVE) begin
      bus_wdata = `IDENT_LEAVE_CODE;
    end else begin
      case (step_q)
        3'h0, 3'h3: begin
          bus_addr  = `UNLOCK1_ADDR;
          bus_wdata = `UNLOCK1_DATA;
        end
        3'h1, 3'h4: begin
          bus_addr  = `UNLOCK2_ADDR;
          bus_wdata = `UNLOCK2_DATA;
        end
        3'h2: begin
          bus_addr = `UNLOCK1_ADDR;
          if (op_q == `OP_PROGRAM) begin
            bus_wdata = `PROGRAM_CODE;
          end else if (op_q == `OP_SET_CONFIG) begin
            bus_wdata = `CONFIG_SET_CODE;
          end else begin
            bus_wdata = `ERASE_SETUP_CODE;
          end
        end
        default: begin
          bus_addr = `UNLOCK1_ADDR;
          bus_wdata = `CHIP_CONFIRM_CODE; // R5
          if (op_q == `OP_SECTOR_ERASE) begin
            bus_addr  = addr_q; // R9
            bus_wdata = `SECTOR_CONFIRM_CODE; // R8
          end
        end
      endcase
      // step three of a program carries the user word; of a configuration, only its low two bits
      if (step_q == 3'h3 && op_q == `OP_PROGRAM) begin
        bus_addr  = addr_q; // R11
        bus_wdata = data_q;
      end else if (step_q == 3'h3 && op_q == `OP_SET_CONFIG) begin
        bus_wdata = {14'h0000, data_q[1:0]};
      end
    end
  end

  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_q        <= S_RST;
      op_q           <= `OP_DEVICE_RESET;
      addr_q         <= 20'h0_0000;
      data_q         <= 16'h0000;
      step_q         <= 3'h0;
      cfg_q          <= `CFG_AUTO_READ;
      first_q        <= 16'h0000;
      pk_q           <= 2'h0;
      timer_q        <= 32'h0000_0000;
      limit_q        <= 32'h0000_0000;
      rcnt_q         <= 8'h00;
      rrec_q         <= 1'b0;
      pend_q         <= 1'b0;
      flash_reset_b  <= 1'b0;
      rsp_valid      <= 1'b0;
      rsp_data       <= 16'h0000;
      rsp_fail       <= 1'b0;
      rsp_supply_low <= 1'b0;
      rsp_timeout    <= 1'b0;
    end else begin
      rsp_valid <= 1'b0;
      if (bus_start) begin
        pend_q <= 1'b1;
      end else if (bus_done) begin
        pend_q <= 1'b0;
      end
      if (timer_q != 32'hFFFF_FFFF) begin
        timer_q <= timer_q + 32'h0000_0001;
      end
      case (state_q)
        S_IDLE: begin
          if (cmd_valid) begin
            op_q           <= cmd_op;
            addr_q         <= cmd_addr;
            data_q         <= cmd_data;
            step_q         <= 3'h0;
            pk_q           <= 2'h0;
            timer_q        <= 32'h0000_0000;
            rsp_fail       <= 1'b0;
            rsp_supply_low <= 1'b0;
            rsp_timeout    <= 1'b0;
            rcnt_q         <= 8'h00;
            rrec_q         <= 1'b0;
            case (cmd_op)
              `OP_PROGRAM:      limit_q <= program_limit;
              `OP_SECTOR_ERASE: limit_q <= sector_limit;
              default:          limit_q <= chip_limit;
            endcase
            if (cmd_op == `OP_READ) begin
              state_q <= S_READ; // R1
            end else if (cmd_op == `OP_DEVICE_RESET) begin
              state_q <= S_RST;
            end else if (cmd_op > `OP_DEVICE_RESET) begin
              state_q <= S_RESP;
            end else begin
              state_q <= S_SEQ;
            end
          end
        end
        S_SEQ: begin
          if (bus_done) begin
            step_q <= step_q + 3'h1;
            if (step_q == last_step) begin
              if (op_q == `OP_SET_CONFIG) begin
                cfg_q   <= data_q[1:0]; // R19
                state_q <= S_RESP;
              end else if (op_q == `OP_IDENT_LEAVE) begin
                state_q <= S_RESP;
              end else begin
                // only reads are issued until the operation ends
                state_q <= S_POLL; // R12
              end
            end
          end
        end
        S_READ: begin
          if (bus_done) begin
            rsp_data <= bus_rdata;
            state_q  <= S_RESP;
          end
        end
        S_POLL: begin
          if (bus_done) begin
            rsp_data <= bus_rdata;
            if (!pk_q[0]) begin
              first_q <= bus_rdata;
              pk_q    <= pk_q + 2'h1;
            end else if (stopped) begin
              // config one holds status after completion, so flags are valid
              rsp_fail       <= hold_cfg & bus_rdata[`FAIL_STATUS_BIT]; // R21
              rsp_supply_low <= hold_cfg & bus_rdata[`SUPPLY_STATUS_BIT]; // R25
              state_q        <= hold_cfg ? S_EXIT : S_RESP; // R17
            end else if (pk_q == 2'h1 && status_flag) begin
              pk_q <= 2'h2; // R22
            end else if (pk_q == 2'h3) begin
              rsp_fail       <= bus_rdata[`FAIL_STATUS_BIT]; // R24
              rsp_supply_low <= bus_rdata[`SUPPLY_STATUS_BIT]; // R16
              state_q        <= S_EXIT; // R18
            end else begin
              pk_q <= 2'h0;
            end
          end else if (!pend_q && timer_q >= limit_q) begin
            // a hung operation is aborted by the reset pin; no read is launched meanwhile
            rsp_timeout <= 1'b1; // R2
            rcnt_q      <= 8'h00;
            rrec_q      <= 1'b0;
            state_q     <= S_RST;
          end
        end
        S_EXIT: begin
          if (bus_done) begin
            state_q <= S_RESP;
          end
        end
        S_RST: begin
          rcnt_q <= rcnt_q + 8'h01;
          if (!rrec_q) begin
            flash_reset_b <= 1'b0; // R2
            if (rcnt_q == `RESET_PULSE_CYCLES - 8'h01) begin
              rrec_q <= 1'b1;
              rcnt_q <= 8'h00;
            end
          end else begin
            flash_reset_b <= 1'b1; // R3
            if (rcnt_q == `RESET_RECOVER_CYCLES - 8'h01) begin
              state_q <= (op_q == `OP_DEVICE_RESET && !rsp_timeout) ? S_RESP : S_RESP;
            end
          end
        end
        S_RESP: begin
          rsp_valid <= 1'b1;
          state_q   <= S_IDLE;
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end

  flash_bus_cycle bus (
    .clock      (clock),
    .rst_b      (rst_b),
    .start      (bus_start),
    .write      (bus_write),
    .addr       (bus_addr),
    .wdata      (bus_wdata),
    .done       (bus_done),
    .rdata      (bus_rdata),
    .ce_b       (ce_b),
    .oe_b       (oe_b),
    .we_b       (we_b),
    .flash_addr (flash_addr),
    .dq_out     (dq_out),
    .dq_oe      (dq_oe),
    .dq_in      (dq_in)
  );

endmodule

/* src/unused_placeholder_none.v */
`timescale 1ns/1ps
// intentionally empty

/* verif/flash_host_ctl_monitor.sv */
// pin checks and response covers for the flash host controller
// assumes a bind to flash_host_ctl, seeing only its ports
`timescale 1ns/1ps
module flash_host_ctl_monitor (
  // clock and reset
  input wire        clock,
  input wire        rst_b,
  // flash pins
  input wire        ce_b,
  input wire        oe_b,
  input wire        we_b,
  input wire        flash_reset_b,
  input wire [19:0] flash_addr,
  input wire [15:0] dq_out,
  input wire        dq_oe,
  // response
  input wire        rsp_valid,
  input wire        rsp_fail,
  input wire        rsp_supply_low
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  chk_read_clean: assert property (!oe_b |-> we_b && !ce_b && !dq_oe)
    else $error("read overlaps write or drive");
  chk_read_ends: assert property ($fell(oe_b) |-> ##[1:4] $rose(oe_b))
    else $error("read strobe stuck low");
  chk_write_qual: assert property (!we_b |-> !ce_b && dq_oe && oe_b)
    else $error("write strobe without chip enable or data");
  chk_we_pulse: assert property ($fell(we_b) |=> $rose(we_b))
    else $error("write pulse not one cycle");
  chk_addr_hold: assert property ($fell(we_b) |=> $stable(flash_addr) && $stable(dq_out))
    else $error("address or data moved in write pulse");
  chk_ce_gap: assert property ($rose(ce_b) |-> ce_b[*2])
    else $error("chip enable gap too short");
  chk_reset_quiet: assert property (!flash_reset_b |-> ce_b && we_b && oe_b)
    else $error("strobes active in device reset");
  chk_reset_width: assert property ($fell(flash_reset_b) |-> !flash_reset_b[*8])
    else $error("device reset pulse too short");
  cover property (rsp_valid && rsp_fail);
  cover property (rsp_valid && rsp_supply_low);
  cover property ($fell(flash_reset_b));
  cover property ($fell(we_b));
endmodule

/* verif/flash_dev_model.sv */
// behavioural flash device: 16 words, command decoder, status polling
// assumes reads are sampled on clock; clock stands in for internal timing
`timescale 1ns/1ps
module flash_dev_model #(
  parameter int busy_cycles = 20
) (
  // timing clock
  input  wire        clock,
  // device pins
  input  wire        ce_b,
  input  wire        oe_b,
  input  wire        we_b,
  input  wire        reset_b,
  input  wire [19:0] addr,
  input  wire [15:0] dq,
  output logic [15:0] dq_rd,
  // bench controls
  input  wire        prot,
  input  wire        vpp_low,
  input  wire        stall
);
  logic [15:0] mem [0:15] = '{default: 16'hFFFF};
  logic [15:0] last_w = 16'h0000;
  logic [15:0] prev_v = 16'h0000;
  logic [15:0] rd_v;
  logic [3:0]  step = 4'h0;
  logic [3:0]  pa = 4'h0;
  logic [1:0]  cfg = 2'h0;
  logic        ers = 1'b0, tog = 1'b0, fail = 1'b0, sup = 1'b0, hold = 1'b0;
  logic        poll;
  int          busy = 0;
  wire         rd = !ce_b && !oe_b && we_b && reset_b;
  assign poll = busy > 0 ? (cfg == 2'h0 && !ers ? ~last_w[7] : 1'b0) : 1'b1;
  assign rd_v = (busy > 0 || hold) ? {8'h00, poll, tog, fail, 1'b0, sup, 3'h0} : mem[addr[3:0]];
  // released bus shows no stale value
  assign dq_rd = rd ? rd_v : ~prev_v;
  always @(posedge clock) if (rd) prev_v <= rd_v;
  always @(negedge oe_b) if (busy > 0 || fail || sup) tog = ~tog;
  always @(posedge clock) if (busy > 0 && !stall) begin
    if (busy == 1 && cfg == 2'h1) hold = 1'b1;
    busy = busy - 1;
  end
  always @(negedge reset_b) begin
    if (busy > 0 && !ers) mem[pa] = 16'hxxxx;
    busy = 0;
    hold = 1'b0;
    fail = 1'b0;
    sup = 1'b0;
    step = 4'h0;
  end
  task automatic start(input bit chk, input bit e);
    if (vpp_low || (prot && chk)) begin
      fail = prot && chk;
      sup = vpp_low;
      hold = 1'b1;
    end else begin
      ers = e;
      busy = busy_cycles;
    end
  endtask
  always @(posedge we_b) if (!ce_b && reset_b && busy == 0) begin
    if (dq[7:0] == 8'hF0) begin
      hold = 1'b0;
      fail = 1'b0;
      sup = 1'b0;
      step = 4'h0;
    end else case (step)
      4'h0: step = (dq[7:0] == 8'hAA && addr == 20'h0_0555) ? 4'h1 : 4'h0;
      4'h1: step = (dq[7:0] == 8'h55 && addr == 20'h0_02AA) ? 4'h2 : 4'h0;
      4'h2: step = dq[7:0] == 8'hA0 ? 4'h8 : dq[7:0] == 8'h80 ? 4'h3 : dq[7:0] == 8'hD0 ? 4'h9 : 4'h0;
      4'h3: step = dq[7:0] == 8'hAA ? 4'h4 : 4'h0;
      4'h4: step = dq[7:0] == 8'h55 ? 4'h5 : 4'h0;
      4'h5: begin
        step = 4'h0;
        if (dq[7:0] == 8'h30 || dq[7:0] == 8'h10) begin
          start(dq[7:0] == 8'h30, 1'b1);
          if (busy > 0 && !prot) for (int i = 0; i < 16; i++) if (dq[7:0] == 8'h10 || i / 4 == addr[3:2]) mem[i] = 16'hFFFF;
        end
      end
      4'h8: begin
        step = 4'h0;
        start(1'b1, 1'b0);
        pa = addr[3:0];
        last_w = dq;
        if (busy > 0) mem[pa] = mem[pa] & dq;
      end
      4'h9: begin
        step = 4'h0;
        cfg = dq[1:0];
      end
      default: step = 4'h0;
    endcase
  end
endmodule

/* verif/flash_host_ctl_tb.sv */
// self-checking bench for the flash host controller
// assumes flash_dev_model on the pins and shortened poll limits
`timescale 1ns/1ps
module flash_host_ctl_tb;
  logic        clock = 1'b0, rst_b = 1'b0, cmd_valid = 1'b0, prot = 1'b0, vpp_low = 1'b0, stall = 1'b0;
  wire         rsp_timeout;
  logic [2:0]  cmd_op = 3'h0;
  logic [19:0] cmd_addr = 20'h0_0000;
  logic [15:0] cmd_data = 16'h0000;
  wire         cmd_ready, rsp_valid, rsp_fail, rsp_supply_low, ce_b, oe_b, we_b, flash_reset_b, dq_oe;
  wire  [1:0]  status_config;
  wire  [19:0] flash_addr;
  wire  [15:0] rsp_data, dq_out, dq_rd;
  wire  [15:0] dq_bus = dq_oe ? dq_out : dq_rd;
  int          num_errors = 0;
  int          cmp_count = 0;
  always #50 clock = ~clock;
  flash_host_ctl #(.word_program_time_us(32'd5), .sector_erase_max_time_us(32'd20),
    .chip_erase_max_time_us(32'd20)) uut (.clock(clock), .rst_b(rst_b), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_fail(rsp_fail), .rsp_supply_low(rsp_supply_low),
    .rsp_timeout(rsp_timeout), .status_config(status_config), .ce_b(ce_b), .oe_b(oe_b), .we_b(we_b),
    .flash_reset_b(flash_reset_b), .flash_addr(flash_addr), .dq_out(dq_out), .dq_oe(dq_oe),
    .dq_in(dq_bus));
  flash_dev_model dev (.clock(clock), .ce_b(ce_b), .oe_b(oe_b), .we_b(we_b), .reset_b(flash_reset_b),
    .addr(flash_addr), .dq(dq_bus), .dq_rd(dq_rd), .prot(prot), .vpp_low(vpp_low), .stall(stall));
  task automatic results();
    if (num_errors == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wait_sig(input bit rsp);
    int n;
    n = 0;
    while ((rsp ? rsp_valid : cmd_ready) !== 1'b1) begin
      @(posedge clock);
      #1;
      n++;
      if (n > 5000) begin
        num_errors++;
        results();
      end
    end
  endtask
  task automatic cmd(input logic [2:0] op, input logic [19:0] a, input logic [15:0] d);
    wait_sig(1'b0);
    cmd_op = op;
    cmd_addr = a;
    cmd_data = d;
    cmd_valid = 1'b1;
    @(posedge clock);
    #1;
    cmd_valid = 1'b0;
    wait_sig(1'b1);
  endtask
  task automatic t_program();
    cmd(3'h0, 20'h0_0002, 16'h0000);
    check("erased word", rsp_data, 16'hFFFF);
    cmd(3'h1, 20'h0_0003, 16'h1234);
    check("poll data", rsp_data, 16'h1234);
    check("no timeout", {15'h0000, rsp_timeout}, 16'h0000);
    cmd(3'h1, 20'h0_0003, 16'hFF0F);
    cmd(3'h0, 20'h0_0003, 16'h0000);
    check("bits cleared", rsp_data, 16'h1204);
  endtask
  task automatic t_erase();
    cmd(3'h1, 20'h0_0005, 16'h0000);
    cmd(3'h2, 20'h0_0003, 16'h0000);
    cmd(3'h0, 20'h0_0003, 16'h0000);
    check("sector erased", rsp_data, 16'hFFFF);
    cmd(3'h0, 20'h0_0005, 16'h0000);
    check("other sector kept", rsp_data, 16'h0000);
    cmd(3'h3, 20'h0_0000, 16'h0000);
    cmd(3'h0, 20'h0_0005, 16'h0000);
    check("chip erased", rsp_data, 16'hFFFF);
  endtask
  task automatic t_config();
    cmd(3'h4, 20'h0_0000, 16'h0001);
    check("config", {14'h0000, status_config}, 16'h0001);
    cmd(3'h1, 20'h0_0006, 16'hA5A5);
    check("held fail", {15'h0000, rsp_fail}, 16'h0000);
    cmd(3'h0, 20'h0_0006, 16'h0000);
    check("read after leave", rsp_data, 16'hA5A5);
  endtask
  task automatic t_protect();
    prot = 1'b1;
    cmd(3'h2, 20'h0_0006, 16'h0000);
    prot = 1'b0;
    check("protected fail", {15'h0000, rsp_fail}, 16'h0001);
    cmd(3'h0, 20'h0_0006, 16'h0000);
    check("protected kept", rsp_data, 16'hA5A5);
  endtask
  task automatic t_supply();
    vpp_low = 1'b1;
    cmd(3'h1, 20'h0_0007, 16'h0000);
    vpp_low = 1'b0;
    check("supply low", {15'h0000, rsp_supply_low}, 16'h0001);
    cmd(3'h0, 20'h0_0007, 16'h0000);
    check("refused program", rsp_data, 16'hFFFF);
  endtask
  task automatic t_timeout();
    stall = 1'b1;
    cmd(3'h1, 20'h0_0008, 16'h0000);
    stall = 1'b0;
    check("poll timeout", {15'h0000, rsp_timeout}, 16'h0001);
    cmd(3'h0, 20'h0_0008, 16'h0000);
    check("aborted word", rsp_data, 16'hxxxx);
  endtask
  task automatic t_reset();
    cmd(3'h6, 20'h0_0000, 16'h0000);
    cmd(3'h5, 20'h0_0000, 16'h0000);
    cmd(3'h7, 20'h0_0000, 16'h0000);
    check("config kept", {14'h0000, status_config}, 16'h0001);
    cmd(3'h0, 20'h0_0006, 16'h0000);
    check("read after reset", rsp_data, 16'hA5A5);
  endtask
  initial begin
    repeat (12) @(posedge clock);
    #1;
    rst_b = 1'b1;
    t_program();
    t_erase();
    t_config();
    t_protect();
    t_supply();
    t_timeout();
    t_reset();
    results();
  end
endmodule
bind flash_host_ctl flash_host_ctl_monitor mon (.clock(clock), .rst_b(rst_b), .ce_b(ce_b), .oe_b(oe_b),
  .we_b(we_b), .flash_reset_b(flash_reset_b), .flash_addr(flash_addr), .dq_out(dq_out), .dq_oe(dq_oe),
  .rsp_valid(rsp_valid), .rsp_fail(rsp_fail), .rsp_supply_low(rsp_supply_low));
